/* common/anlpi_pkg.sv */
// anlpi_pkg: constants, register map and carrier types of the negotiation / lpi controller
// assumes a 25 MHz system clock; all timing counts derive from that rate
package anlpi_pkg;
  localparam int CLK_MHZ = 25;
  // ****************************************
  // interval times, as printed, in their own units
  // ****************************************
  localparam int FLP_MIN_NS = 17200;
  localparam int FLP_MAX_NS = 185000;
  localparam int PD_WAIT_MS = 830;
  localparam int LINK_EN_WAIT_MS = 1000;
  localparam int FLF_MS = 1;
  localparam int REFRESH_PERIOD_MS = 20;
  localparam int REFRESH_LEN_US = 200;
  localparam int LPI_WAIT_MS = 1000;
  // least times round up, longest round down
  localparam int FLP_MIN_CYC = (FLP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int FLP_MAX_CYC = (FLP_MAX_NS * CLK_MHZ) / 1000;
  localparam int PD_WAIT_CYC = PD_WAIT_MS * 1000 * CLK_MHZ;
  localparam int LINK_EN_WAIT_CYC = LINK_EN_WAIT_MS * 1000 * CLK_MHZ;
  localparam int FLF_CYC = FLF_MS * 1000 * CLK_MHZ;
  localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int REFRESH_LEN_CYC = REFRESH_LEN_US * CLK_MHZ;
  localparam int LPI_WAIT_CYC = LPI_WAIT_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 32;
  localparam int FLP_W = 13;
  localparam logic [FLP_W-1:0] FLP_MIN = FLP_W'(FLP_MIN_CYC);
  localparam logic [FLP_W-1:0] FLP_MAX = FLP_W'(FLP_MAX_CYC);
  localparam int TX_HOLD = 9;
  // ****************************************
  // register map (byte-free word index on the plain port)
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_NP_TX = 8'h02;
  localparam logic [7:0] REG_NP_RX = 8'h03;
  localparam logic [7:0] REG_EEE_MSG = 8'h04;
  localparam logic [7:0] REG_EEE_ADV = 8'h3C;
  // control fields
  localparam int C_RESTART = 9;
  localparam int C_NP_REQ = 0;
  localparam int C_PD_FD100 = 1;
  localparam int C_PD_FD10 = 2;
  localparam int C_FLF_EN = 3;
  localparam int C_LPI_WAIT = 4;
  localparam int C_CLK_STOP = 5;
  localparam int A_EEE1000 = 2;
  localparam int A_EEE100 = 1;
  localparam logic [15:0] CTRL_RST = 16'h0010;
  localparam logic [15:0] EEE_ADV_RST = 16'h0006;
  localparam logic [10:0] MSG_GIG = 11'h008;
  localparam logic [10:0] MSG_EEE = 11'h00A;
  localparam logic [15:0] NP_NEXT = 16'h8000;
  localparam logic [15:0] NP_MSG = 16'h2000;
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  // ****************************************
  // carrier types
  // ****************************************
  typedef enum logic [2:0] {
    NP_IDLE = 3'h0,
    NP_GIG_MSG = 3'h1,
    NP_GIG_U1 = 3'h2,
    NP_GIG_U2 = 3'h3,
    NP_EEE_MSG = 3'h4,
    NP_EEE_U1 = 3'h5,
    NP_SW = 3'h6,
    NP_DONE = 3'h7
  } anlpi_np_t;
  typedef enum logic [1:0] {
    LK_DOWN = 2'h0,
    LK_PD_WAIT = 2'h1,
    LK_EN_WAIT = 2'h2,
    LK_UP = 2'h3
  } anlpi_link_t;
  typedef struct packed {
    logic txCtlRise;
    logic txCtlFall;
    logic [3:0] txdRise;
    logic [3:0] txdFall;
  } anlpi_rgmii_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } anlpi_bus_t;
endpackage : anlpi_pkg

/* rtl/anlpi_ctrl.sv */
// anlpi_ctrl: negotiation timers, next-page sequencing, fast link failure and tx lpi decode
// assumes line-side events arrive as async levels; rgmii pins and txc are sampled, not clocked on
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
module anlpi_ctrl #(
  parameter int PD_WAIT = anlpi_pkg::PD_WAIT_CYC,
  parameter int LINK_EN_WAIT = anlpi_pkg::LINK_EN_WAIT_CYC,
  parameter int FLF_WIN = anlpi_pkg::FLF_CYC,
  parameter int REFRESH_PERIOD = anlpi_pkg::REFRESH_PERIOD_CYC,
  parameter int REFRESH_LEN = anlpi_pkg::REFRESH_LEN_CYC,
  parameter int LPI_WAIT = anlpi_pkg::LPI_WAIT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire anlpi_pkg::anlpi_bus_t bus,
  output logic [15:0] rdata,
  input wire logic linkPulse,
  input wire logic pdSignal,
  input wire logic [1:0] pdSpeed,
  input wire logic pageAck,
  input wire logic [15:0] rxPage,
  input wire logic [1:0] resolvedSpeed,
  input wire logic remoteRxOk,
  input wire logic descramLock,
  input wire logic rxLpi,
  input wire logic txc,
  input wire logic txCtl,
  input wire logic [3:0] txd,
  input wire logic [15:0] msCtrl,
  input wire logic [10:0] msSeed,
  output logic [15:0] txPage,
  output logic txPageValid,
  output logic linkUp,
  output logic fullDuplex,
  output logic [1:0] linkSpeed,
  output logic inbandLinkOk,
  output logic txLpi,
  output logic rxLpiState,
  output logic refreshOn,
  output logic clockStopCapable
);
  typedef struct packed {
    logic [1:0] pulseS;
    logic [1:0] pdS;
    logic [1:0] ackS;
    logic [1:0] remS;
    logic [1:0] lockS;
    logic [1:0] rxLpiS;
    logic [1:0] txcS;
    logic [1:0] ctlS;
    logic [7:0] txdS;
    logic pulsePrev;
    logic ackPrev;
    logic txcPrev;
    logic [anlpi_pkg::FLP_W-1:0] flpCnt;
    logic flpSeen;
    logic [31:0] linkCnt;
    logic [31:0] flfCnt;
    logic [31:0] refCnt;
    logic [31:0] lpiWaitCnt;
    logic [3:0] holdCnt;
    anlpi_pkg::anlpi_link_t linkSt;
    anlpi_pkg::anlpi_np_t npSt;
    logic pdPath;
    anlpi_pkg::anlpi_rgmii_t pins;
    logic [15:0] ctrl;
    logic [15:0] eeeAdv;
    logic [15:0] eeeAdvLive;
    logic [10:0] eeeMsg;
    logic [15:0] npTx;
    logic [15:0] npRx;
    logic npRxNew;
    logic [15:0] rdata;
    logic [15:0] txPage;
    logic txPageValid;
    logic linkUp;
    logic fullDuplex;
    logic [1:0] linkSpeed;
    logic inbandLinkOk;
    logic txLpi;
    logic rxLpiState;
    logic refreshOn;
  } anlpi_state_t;

  anlpi_state_t st;
  anlpi_state_t next_st;

  // ****************************************
  // helpers
  // ****************************************
  // counter step saturating at a limit, shared by the link, fast link failure and lpi wait timers
  function automatic logic [31:0] anlpi_tick(input logic [31:0] c, input int lim);
    anlpi_tick = (c >= 32'(lim)) ? c : c + 32'h1;
  endfunction : anlpi_tick

  // lpi pattern of the sampled rgmii word at the current speed
  function automatic logic anlpi_is_lpi(input anlpi_pkg::anlpi_rgmii_t p, input logic [1:0] spd);
    if (spd == anlpi_pkg::SPD_1000) begin
      anlpi_is_lpi = !p.txCtlRise && p.txCtlFall && p.txdRise == 4'h1 && p.txdFall == 4'h0;
    end else begin
      anlpi_is_lpi = !p.txCtlRise && p.txCtlFall && p.txdRise == 4'h1;
    end
  endfunction : anlpi_is_lpi

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic pulseEdge;
    logic ackEdge;
    logic txcRise;
    logic txcFall;
    logic restart;
    logic flfEvent;
    logic lpiPat;
    pulseEdge = 1'b0;
    ackEdge = 1'b0;
    txcRise = 1'b0;
    txcFall = 1'b0;
    restart = 1'b0;
    flfEvent = 1'b0;
    lpiPat = 1'b0;
    next_st = st;
    // two-flop synchronisers; only stage one feeds stage two
    next_st.pulseS = {st.pulseS[0], linkPulse};
    next_st.pdS = {st.pdS[0], pdSignal};
    next_st.ackS = {st.ackS[0], pageAck};
    next_st.remS = {st.remS[0], remoteRxOk};
    next_st.lockS = {st.lockS[0], descramLock};
    next_st.rxLpiS = {st.rxLpiS[0], rxLpi};
    next_st.txcS = {st.txcS[0], txc};
    next_st.ctlS = {st.ctlS[0], txCtl};
    next_st.txdS = {st.txdS[3:0], txd};
    next_st.pulsePrev = st.pulseS[1];
    next_st.ackPrev = st.ackS[1];
    next_st.txcPrev = st.txcS[1];
    pulseEdge = st.pulseS[1] && !st.pulsePrev;
    ackEdge = st.ackS[1] && !st.ackPrev;
    txcRise = st.txcS[1] && !st.txcPrev;
    txcFall = !st.txcS[1] && st.txcPrev;

    // register writes; restart is self-clearing
    if (bus.wr) begin
      unique case (bus.addr)
        anlpi_pkg::REG_CTRL: begin
          next_st.ctrl = bus.wdata & ~(16'h1 << anlpi_pkg::C_RESTART);
          restart = bus.wdata[anlpi_pkg::C_RESTART];
        end
        anlpi_pkg::REG_NP_TX: next_st.npTx = bus.wdata;
        anlpi_pkg::REG_EEE_MSG: next_st.eeeMsg = bus.wdata[10:0];
        anlpi_pkg::REG_EEE_ADV: next_st.eeeAdv = bus.wdata;
        default: ;
      endcase
    end
    // reads answer one cycle later; unmapped reads give zero
    next_st.rdata = 16'h0000;
    if (bus.rd) begin
      unique case (bus.addr)
        anlpi_pkg::REG_CTRL: next_st.rdata = st.ctrl;
        anlpi_pkg::REG_STATUS: next_st.rdata = {7'h00, st.npRxNew, st.npSt, st.linkSt,
                                                st.txLpi, st.rxLpiState, st.inbandLinkOk};
        anlpi_pkg::REG_NP_TX: next_st.rdata = st.npTx;
        anlpi_pkg::REG_NP_RX: next_st.rdata = st.npRx;
        anlpi_pkg::REG_EEE_MSG: next_st.rdata = {5'h00, st.eeeMsg};
        anlpi_pkg::REG_EEE_ADV: next_st.rdata = st.eeeAdv;
        default: next_st.rdata = 16'h0000;
      endcase
      // reading the received page clears its flag unless a new one lands now
      if (bus.addr == anlpi_pkg::REG_NP_RX) begin
        next_st.npRxNew = 1'b0;
      end
    end

    // link pulse window check
    next_st.flpCnt = (st.flpCnt == {anlpi_pkg::FLP_W{1'b1}}) ? st.flpCnt : st.flpCnt + 1'b1;
    if (pulseEdge) begin
      next_st.flpSeen = st.flpCnt >= anlpi_pkg::FLP_MIN && st.flpCnt <= anlpi_pkg::FLP_MAX;
      next_st.flpCnt = '0;
    end

    // link state machine
    unique case (st.linkSt)
      anlpi_pkg::LK_DOWN: begin
        next_st.linkCnt = 32'h0;
        if (st.pdS[1]) begin
          next_st.linkSt = anlpi_pkg::LK_PD_WAIT;
          next_st.pdPath = 1'b1;
        end else if (st.npSt == anlpi_pkg::NP_DONE && st.flpSeen) begin
          next_st.linkSt = anlpi_pkg::LK_EN_WAIT;
          next_st.pdPath = 1'b0;
        end
      end
      anlpi_pkg::LK_PD_WAIT: begin
        next_st.linkCnt = anlpi_tick(st.linkCnt, PD_WAIT);
        if (!st.pdS[1]) next_st.linkSt = anlpi_pkg::LK_DOWN;
        else if (st.linkCnt >= 32'(PD_WAIT - 1)) begin
          next_st.linkSt = anlpi_pkg::LK_EN_WAIT;
          next_st.linkCnt = 32'h0;
        end
      end
      anlpi_pkg::LK_EN_WAIT: begin
        next_st.linkCnt = anlpi_tick(st.linkCnt, LINK_EN_WAIT);
        if (st.linkCnt >= 32'(LINK_EN_WAIT - 1)) begin
          next_st.linkSt = anlpi_pkg::LK_UP;
          next_st.linkUp = 1'b1;
          next_st.lpiWaitCnt = 32'h0;
          next_st.linkSpeed = st.pdPath ? pdSpeed : resolvedSpeed;
          if (st.pdPath) begin
            next_st.fullDuplex = (pdSpeed == anlpi_pkg::SPD_100 && st.ctrl[anlpi_pkg::C_PD_FD100])
              || (pdSpeed == anlpi_pkg::SPD_10 && st.ctrl[anlpi_pkg::C_PD_FD10]);
          end else begin
            next_st.fullDuplex = 1'b1;
          end
        end
      end
      anlpi_pkg::LK_UP: ;
    endcase

    // fast link failure detection
    if (st.linkUp && st.ctrl[anlpi_pkg::C_FLF_EN]) begin
      if (st.linkSpeed == anlpi_pkg::SPD_1000) begin
        flfEvent = !st.remS[1] || !st.lockS[1];
      end else if (st.linkSpeed == anlpi_pkg::SPD_100) begin
        flfEvent = !st.lockS[1];
      end
    end
    next_st.flfCnt = flfEvent ? anlpi_tick(st.flfCnt, FLF_WIN) : 32'h0;
    next_st.inbandLinkOk = st.linkUp;
    if (st.flfCnt >= 32'(FLF_WIN - 1)) begin
      next_st.inbandLinkOk = 1'b0;
      next_st.linkUp = 1'b0;
      next_st.linkSt = anlpi_pkg::LK_DOWN;
    end

    // next-page sequencer: gigabit, then eee, then software
    next_st.txPageValid = st.npSt != anlpi_pkg::NP_IDLE && st.npSt != anlpi_pkg::NP_DONE;
    if (ackEdge) begin
      next_st.npRx = rxPage;
      next_st.npRxNew = 1'b1; // set wins over a same-cycle read clear
    end
    unique case (st.npSt)
      anlpi_pkg::NP_IDLE: begin
        next_st.npSt = anlpi_pkg::NP_GIG_MSG;
        next_st.txPage = anlpi_pkg::NP_NEXT | anlpi_pkg::NP_MSG | {5'h00, anlpi_pkg::MSG_GIG};
      end
      anlpi_pkg::NP_GIG_MSG: if (ackEdge) begin
        next_st.npSt = anlpi_pkg::NP_GIG_U1;
        next_st.txPage = anlpi_pkg::NP_NEXT | {5'h00, msCtrl[10:0]};
      end
      anlpi_pkg::NP_GIG_U1: if (ackEdge) begin
        next_st.npSt = anlpi_pkg::NP_GIG_U2;
        next_st.txPage = anlpi_pkg::NP_NEXT | {5'h00, msSeed};
      end
      anlpi_pkg::NP_GIG_U2: if (ackEdge) begin
        if (st.eeeAdvLive != 16'h0000) begin
          next_st.npSt = anlpi_pkg::NP_EEE_MSG;
          next_st.txPage = anlpi_pkg::NP_NEXT | anlpi_pkg::NP_MSG | {5'h00, st.eeeMsg};
        end else if (st.ctrl[anlpi_pkg::C_NP_REQ]) begin
          next_st.npSt = anlpi_pkg::NP_SW;
          next_st.txPage = st.npTx;
        end else begin
          next_st.npSt = anlpi_pkg::NP_DONE;
        end
      end
      anlpi_pkg::NP_EEE_MSG: if (ackEdge) begin
        next_st.npSt = anlpi_pkg::NP_EEE_U1;
        next_st.txPage = {5'h00, st.eeeAdvLive[10:0]} | (st.ctrl[anlpi_pkg::C_NP_REQ] ?
                         anlpi_pkg::NP_NEXT : 16'h0000);
      end
      anlpi_pkg::NP_EEE_U1: if (ackEdge) begin
        next_st.npSt = st.ctrl[anlpi_pkg::C_NP_REQ] ? anlpi_pkg::NP_SW : anlpi_pkg::NP_DONE;
        next_st.txPage = st.npTx;
      end
      anlpi_pkg::NP_SW: begin
        next_st.txPage = st.npTx;
        if (ackEdge && !st.npTx[15]) next_st.npSt = anlpi_pkg::NP_DONE;
      end
      anlpi_pkg::NP_DONE: ;
    endcase

    // restart reloads advertisement and reruns the page sequence
    if (restart) begin
      next_st.eeeAdvLive = next_st.eeeAdv;
      next_st.npSt = anlpi_pkg::NP_IDLE;
      next_st.linkSt = anlpi_pkg::LK_DOWN;
      next_st.linkUp = 1'b0;
      next_st.inbandLinkOk = 1'b0;
      next_st.flpSeen = 1'b0;
    end

    // rgmii transmit sampling on found txc edges
    if (txcRise) begin
      next_st.pins.txCtlRise = st.ctlS[1];
      next_st.pins.txdRise = st.txdS[7:4];
    end
    if (txcFall) begin
      next_st.pins.txCtlFall = st.ctlS[1];
      next_st.pins.txdFall = st.txdS[7:4];
    end

    // transmit lpi, gated by eee_advertise at the link speed and the wait after link up
    next_st.lpiWaitCnt = st.linkUp ? anlpi_tick(st.lpiWaitCnt, LPI_WAIT) : 32'h0;
    lpiPat = anlpi_is_lpi(st.pins, st.linkSpeed)
      && ((st.linkSpeed == anlpi_pkg::SPD_1000 && st.eeeAdvLive[anlpi_pkg::A_EEE1000])
       || (st.linkSpeed == anlpi_pkg::SPD_100 && st.eeeAdvLive[anlpi_pkg::A_EEE100]))
      && st.linkUp
      && (!st.ctrl[anlpi_pkg::C_LPI_WAIT] || st.lpiWaitCnt >= 32'(LPI_WAIT));
    if (lpiPat && txcRise) begin
      next_st.holdCnt = (st.holdCnt == 4'hF) ? st.holdCnt : st.holdCnt + 4'h1;
    end
    if (!lpiPat) next_st.holdCnt = 4'h0;
    // a stopped txc freezes the sampled pattern, so lpi holds through it
    // gated by the next link state so lpi never outlives the link by a cycle
    next_st.txLpi = lpiPat && next_st.linkUp;
    next_st.rxLpiState = st.rxLpiS[1] && st.linkUp;

    // refresh burst scheduler while transmit lpi holds
    // keyed to the next lpi value so a burst ends on the same edge as lpi
    if (next_st.txLpi) begin
      next_st.refCnt = (st.refCnt >= 32'(REFRESH_PERIOD - 1)) ? 32'h0 : st.refCnt + 32'h1;
      next_st.refreshOn = st.refCnt < 32'(REFRESH_LEN);
    end else begin
      next_st.refCnt = 32'h0;
      next_st.refreshOn = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
      st.ctrl <= anlpi_pkg::CTRL_RST;
      st.eeeAdv <= anlpi_pkg::EEE_ADV_RST;
      st.eeeAdvLive <= anlpi_pkg::EEE_ADV_RST;
      st.eeeMsg <= anlpi_pkg::MSG_EEE;
      st.flpCnt <= '1;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // outputs straight from the state record
  assign rdata = st.rdata;
  assign txPage = st.txPage;
  assign txPageValid = st.txPageValid;
  assign linkUp = st.linkUp;
  assign fullDuplex = st.fullDuplex;
  assign linkSpeed = st.linkSpeed;
  assign inbandLinkOk = st.inbandLinkOk;
  assign txLpi = st.txLpi;
  assign rxLpiState = st.rxLpiState;
  assign refreshOn = st.refreshOn;
  assign clockStopCapable = st.ctrl[anlpi_pkg::C_CLK_STOP];
endmodule : anlpi_ctrl

/* tb/anlpi_checker.sv */
// anlpi_checker: port-level assertions for the negotiation / lpi controller
// assumes one clk domain with synchronous sys_rst; bound onto anlpi_ctrl
`timescale 1ns/1ns
module anlpi_checker #(
  parameter int REFRESH_LEN = anlpi_pkg::REFRESH_LEN_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire anlpi_pkg::anlpi_bus_t bus,
  input wire logic [15:0] rdata,
  input wire logic linkUp,
  input wire logic [1:0] linkSpeed,
  input wire logic inbandLinkOk,
  input wire logic txLpi,
  input wire logic refreshOn,
  input wire logic clockStopCapable
);
  // ****************************************
  // helpers and properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] refCnt;
  logic ctrlWr;
  assign ctrlWr = clkEn && bus.wr && bus.addr == anlpi_pkg::REG_CTRL;
  // age of the running refresh burst; truncation by lpi exit is allowed
  always_ff @(posedge clk) begin
    if (sys_rst || !refreshOn)
      refCnt <= 32'h0;
    else
      refCnt <= refCnt + 32'h1;
  end
  property p_rd_idle;
    !$past(clkEn && bus.rd) |-> rdata == 16'h0000;
  endproperty
  property p_unmapped;
    clkEn && bus.rd && bus.addr > anlpi_pkg::REG_EEE_MSG &&
      bus.addr != anlpi_pkg::REG_EEE_ADV |=> rdata == 16'h0000;
  endproperty
  property p_clk_stop;
    ctrlWr |=> clockStopCapable == $past(bus.wdata[anlpi_pkg::C_CLK_STOP]);
  endproperty
  property p_restart;
    ctrlWr && bus.wdata[anlpi_pkg::C_RESTART] |-> ##[1:4] !linkUp;
  endproperty
  property p_lpi_link;
    txLpi |-> linkUp;
  endproperty
  property p_ref_lpi;
    refreshOn |-> txLpi;
  endproperty
  property p_ref_len;
    refreshOn |-> refCnt < REFRESH_LEN;
  endproperty
  property p_inband;
    inbandLinkOk |-> linkUp;
  endproperty
  property p_speed;
    linkUp && $past(linkUp) |-> $stable(linkSpeed);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata nonzero outside read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_clk_stop: assert property (p_clk_stop) else $error("clock stop flag wrong");
  a_restart: assert property (p_restart) else $error("restart kept link");
  a_lpi_link: assert property (p_lpi_link) else $error("tx lpi without link");
  a_ref_lpi: assert property (p_ref_lpi) else $error("refresh outside lpi");
  a_ref_len: assert property (p_ref_len) else $error("refresh burst too long");
  a_inband: assert property (p_inband) else $error("inband ok without link");
  a_speed: assert property (p_speed) else $error("speed moved during link");
  c_lpi: cover property ($rose(txLpi));
  c_ref: cover property ($rose(refreshOn));
  c_flf: cover property ($fell(inbandLinkOk));
endmodule : anlpi_checker
bind anlpi_ctrl anlpi_checker #(.REFRESH_LEN(REFRESH_LEN)) u_chk (.clk(clk),
  .sys_rst(sys_rst), .clkEn(clkEn), .bus(bus), .rdata(rdata), .linkUp(linkUp),
  .linkSpeed(linkSpeed), .inbandLinkOk(inbandLinkOk), .txLpi(txLpi),
  .refreshOn(refreshOn), .clockStopCapable(clockStopCapable));

/* tb/anlpi_mac_model.sv */
// anlpi_mac_model: behavioural eee mac driving the rgmii transmit pins at 1000 mbps
// assumes txc period of 320 ns; data settles a quarter period before each txc edge
`timescale 1ns/1ns
module anlpi_mac_model (
  input wire logic lpiReq,
  input wire logic stopClk,
  output logic txc,
  output logic txCtl,
  output logic [3:0] txd
);
  // ****************************************
  // txc generation and lpi pattern
  // ****************************************
  int held;
  logic parked;
  logic lp;
  // one loop pass is one txc period; a parked clock still steps in 320 ns slots
  initial begin
    txc = 1'b0;
    txCtl = 1'b0;
    txd = 4'h0;
    held = 0;
    parked = 1'b0;
    forever begin
      if (lpiReq && stopClk && held >= 9) begin
        // clock parked only after nine lpi cycles, pins held low
        parked = 1'b1;
        txCtl = 1'b0;
        txd = 4'h0;
        #320;
      end else begin
        // after a park, one full lpi cycle before the exit pattern
        lp = lpiReq || parked;
        parked = 1'b0;
        held = lp ? held + 1 : 0;
        txCtl = 1'b0;
        txd = lp ? 4'h1 : 4'h0;
        #80 txc = 1'b1;
        #80 txCtl = lp;
        txd = 4'h0;
        #80 txc = 1'b0;
        #80;
      end
    end
  end
endmodule : anlpi_mac_model

/* tb/tb_top.sv */
// tb_top: register, negotiation, lpi and fast link failure tests for anlpi_ctrl
// assumes shortened timer parameters and the mac model on the rgmii tx pins
`timescale 1ns/1ns
module tb_top;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic clkEn = 1'b1;
  logic linkPulse = 1'b0;
  logic pageAck = 1'b0;
  logic remoteRxOk = 1'b1;
  logic descramLock = 1'b1;
  logic rxLpi = 1'b0;
  logic pdSignal = 1'b0;
  logic [1:0] pdSpeed = 2'h0;
  logic lpiReq = 1'b0;
  logic stopClk = 1'b0;
  logic [15:0] rxPage = 16'h0000;
  logic [15:0] msCtrl = 16'h0400;
  logic [10:0] msSeed = 11'h5A3;
  logic [1:0] resSpeed = anlpi_pkg::SPD_1000;
  anlpi_pkg::anlpi_bus_t bus = '0;
  logic [15:0] rdata;
  logic [15:0] txPage;
  logic [1:0] linkSpeed;
  logic txPageValid, linkUp, fullDuplex, inbandLinkOk, txLpi, rxLpiState;
  logic refreshOn, clockStopCapable, txc, txCtl;
  logic [3:0] txd;
  logic [5:0] st;
  logic [10:0] expPg [5];
  int miscompares = 0;
  int checks_done = 0;
  assign st = {txPageValid, linkUp, txLpi, refreshOn, rxLpiState, inbandLinkOk};
  always #20 clk = ~clk;
  anlpi_ctrl #(.PD_WAIT(200), .LINK_EN_WAIT(200), .FLF_WIN(20), .REFRESH_PERIOD(500),
    .REFRESH_LEN(5), .LPI_WAIT(50)) DUT (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn),
    .bus(bus), .rdata(rdata), .linkPulse(linkPulse), .pdSignal(pdSignal), .pdSpeed(pdSpeed),
    .pageAck(pageAck), .rxPage(rxPage), .resolvedSpeed(resSpeed),
    .remoteRxOk(remoteRxOk), .descramLock(descramLock), .rxLpi(rxLpi), .txc(txc),
    .txCtl(txCtl), .txd(txd), .msCtrl(msCtrl), .msSeed(msSeed), .txPage(txPage),
    .txPageValid(txPageValid), .linkUp(linkUp), .fullDuplex(fullDuplex),
    .linkSpeed(linkSpeed), .inbandLinkOk(inbandLinkOk), .txLpi(txLpi),
    .rxLpiState(rxLpiState), .refreshOn(refreshOn), .clockStopCapable(clockStopCapable));
  anlpi_mac_model u_mac (.lpiReq(lpiReq), .stopClk(stopClk), .txc(txc), .txCtl(txCtl),
    .txd(txd));
  // ****************************************
  // tasks
  // ****************************************
  task end_of_test;
    $display("counts checks=%0d bad=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk(rdata, exp);
  endtask : rd
  // bounded wait on one status bit, then compare it
  task expBit(input int b, input logic v, input int n);
    for (int k = 0; k < n && st[b] !== v; k++) @(posedge clk);
    chk({15'h0, st[b]}, {15'h0, v});
  endtask : expBit
  // restart, answer n pages, then expect the link to come up
  task neg(input int n, input logic [15:0] ctl);
    wr(anlpi_pkg::REG_CTRL, ctl | 16'h0200);
    for (int k = 0; k < n; k++) begin
      expBit(5, 1'b1, 3000);
      chk({5'h0, txPage[10:0]}, {5'h0, expPg[k]});
      @(posedge clk);
      rxPage <= anlpi_pkg::NP_NEXT | 16'(k);
      pageAck <= 1'b1;
      repeat (6) @(posedge clk);
      pageAck <= 1'b0;
      repeat (10) @(posedge clk);
    end
    expBit(4, 1'b1, 3000);
  endtask : neg
  // ****************************************
  // stimulus
  // ****************************************
  // link pulses every 40 us, inside the accepted spacing window
  initial begin
    forever begin
      repeat (1000) @(posedge clk);
      linkPulse <= 1'b1;
      repeat (4) @(posedge clk);
      linkPulse <= 1'b0;
    end
  end
  // hang guard sized well beyond the longest expected sequence
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    sysRst <= 1'b0;
    rd(anlpi_pkg::REG_CTRL, 16'h0010);
    rd(anlpi_pkg::REG_EEE_ADV, 16'h0006);
    rd(anlpi_pkg::REG_EEE_MSG, 16'h000A);
    rd(8'h20, 16'h0000);
    wr(anlpi_pkg::REG_CTRL, 16'h0030);
    rd(anlpi_pkg::REG_CTRL, 16'h0030);
    chk({15'h0, clockStopCapable}, 16'h0001);
    $display("test registers done");
    // zero advertisement: gigabit pages only, even with no gigabit abilities
    wr(anlpi_pkg::REG_EEE_ADV, 16'h0000);
    expPg = '{anlpi_pkg::MSG_GIG, msCtrl[10:0], msSeed, 11'h000, 11'h000};
    neg(3, 16'h0030);
    $display("test no eee pages done");
    // eee pages with an overridden message code
    wr(anlpi_pkg::REG_EEE_MSG, 16'h000B);
    wr(anlpi_pkg::REG_EEE_ADV, 16'h0006);
    expPg = '{anlpi_pkg::MSG_GIG, msCtrl[10:0], msSeed, 11'h00B, 11'h006};
    neg(5, 16'h0030);
    $display("test eee pages done");
    // lpi held off after link up, then refresh, rx lpi, clock stop, exit
    lpiReq <= 1'b1;
    repeat (30) @(posedge clk);
    chk({15'h0, txLpi}, 16'h0000);
    expBit(3, 1'b1, 100);
    expBit(2, 1'b1, 600);
    rxLpi <= 1'b1;
    expBit(1, 1'b1, 20);
    stopClk <= 1'b1;
    repeat (200) @(posedge clk);
    expBit(3, 1'b1, 1);
    lpiReq <= 1'b0;
    expBit(3, 1'b0, 60);
    stopClk <= 1'b0;
    rxLpi <= 1'b0;
    $display("test lpi done");
    // fast link failure on remote receiver loss at 1000
    wr(anlpi_pkg::REG_CTRL, 16'h0038);
    expBit(0, 1'b1, 40);
    remoteRxOk <= 1'b0;
    expBit(0, 1'b0, 40);
    $display("test fast link fail done");
    // parallel detect: full duplex only at the speed whose override is set
    remoteRxOk <= 1'b1;
    pdSpeed <= anlpi_pkg::SPD_100;
    pdSignal <= 1'b1;
    wr(anlpi_pkg::REG_CTRL, 16'h0232);
    expBit(4, 1'b1, 600);
    chk({14'h0, linkSpeed}, {14'h0, anlpi_pkg::SPD_100});
    chk({15'h0, fullDuplex}, 16'h0001);
    pdSpeed <= anlpi_pkg::SPD_10;
    wr(anlpi_pkg::REG_CTRL, 16'h0232);
    expBit(4, 1'b0, 5);
    expBit(4, 1'b1, 600);
    chk({14'h0, linkSpeed}, {14'h0, anlpi_pkg::SPD_10});
    chk({15'h0, fullDuplex}, 16'h0000);
    $display("test parallel detect done");
    // a low enable freezes all state, so this write must not land
    clkEn <= 1'b0;
    wr(anlpi_pkg::REG_EEE_MSG, 16'h0077);
    clkEn <= 1'b1;
    rd(anlpi_pkg::REG_EEE_MSG, 16'h000B);
    $display("test clock enable done");
    end_of_test;
  end
endmodule : tb_top
